//--- design/hs_start_consts.svh
/*
 * Named constants for the high-speed start decoder: command codes, field
 * positions, axis limits and block sizes.
 * Assumes it is included by bare name after the package.
 */
`ifndef HS_START_CONSTS_SVH
`define HS_START_CONSTS_SVH

// =====================================================================
// Control word fields
// =====================================================================
`define MOVE_HI       15
`define MOVE_LO       8
`define AXIS_HI       7
`define AXIS_LO       0
`define CODE_IMM_ABS  8'h00
`define CODE_IMM_REL  8'h01
`define CODE_WR_ABS   8'h80
`define CODE_WR_REL   8'h81
`define AXIS_FIRST    8'h01
`define AXIS_LAST     8'h10
`define REL_BIT       0

// =====================================================================
// Destination and transfer fields
// =====================================================================
`define UNIT_BASE     12'h800
`define UNIT_HI       15
`define UNIT_LO       4
`define UNIT_NO_HI    3
`define UNIT_NO_LO    0
`define WORD_COUNT    16'h000C
`define BLOCK_WORDS   8'h0C

// =====================================================================
// Start sequencing
// =====================================================================
`define ACK_HOLD      2'h1
`define AXES          16

`endif

//--- design/hs_start_pkg.sv
/*
 * Types shared by the start decoder files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package hs_start_pkg;

    // Command as presented by the host on one cycle.
    typedef struct packed {
        logic        imm;
        logic [15:0] ctrl;
        logic [15:0] dest;
        logic [15:0] count;
        logic [15:0] src;
    } cmd_s;

    // Result flags returned to the host.
    typedef struct packed {
        logic eq;
        logic err;
    } flags_s;

    // Decoded start handed to the positioning path.
    typedef struct packed {
        logic        rel;
        logic [3:0]  axis;
        logic [15:0] block;
    } start_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_BUSY = 3'b100
    } seq_e;

endpackage

//--- design/ctrl_decode.sv
/*
 * Combinational decoder of one start command into a validity flag,
 * movement type, axis index and command block address.
 * Assumes the command is stable for the cycle it is presented.
 */
`timescale 1ns/1ns
`include "hs_start_consts.svh"

module ctrl_decode (
    // Command in
    input  wire hs_start_pkg::cmd_s  cmd,
    input  wire logic [3:0]          unit_no,
    input  wire logic [15:0]         base_addr,
    // Decode out
    output logic                     ok,
    output hs_start_pkg::start_s     dec
);

    logic [7:0]  code;
    logic [7:0]  ax;
    logic        code_ok;
    logic        axis_ok;
    logic        unit_ok;
    logic        cnt_ok;
    logic [3:0]  idx;

    // Checks on the ctrl, dest and count fields of the command; src is not checked.
    always_comb begin
        code = cmd.ctrl[`MOVE_HI:`MOVE_LO];
        ax   = cmd.ctrl[`AXIS_HI:`AXIS_LO];
        if (cmd.imm) begin
            code_ok = (code == `CODE_IMM_ABS) || (code == `CODE_IMM_REL);
        end else begin
            code_ok = (code == `CODE_WR_ABS) || (code == `CODE_WR_REL);
        end
        axis_ok = (ax >= `AXIS_FIRST) && (ax <= `AXIS_LAST);
        unit_ok = (cmd.dest[`UNIT_HI:`UNIT_LO] == `UNIT_BASE)
                  && (cmd.dest[`UNIT_NO_HI:`UNIT_NO_LO] == unit_no);
        cnt_ok  = cmd.imm || (cmd.count == `WORD_COUNT);
        ok      = code_ok && axis_ok && unit_ok && cnt_ok;
        idx     = 4'(ax - `AXIS_FIRST);
        dec.rel   = code[`REL_BIT];
        dec.axis  = idx;
        dec.block = 16'(base_addr + 16'(idx) * 16'(`BLOCK_WORDS));
    end

endmodule // ctrl_decode

//--- design/hs_start_decoder.sv
/*
 * High-speed point-to-point start decoder of the positioning unit.
 * Takes start commands from the host, checks them, issues one axis start
 * to the direct-operation path and returns condition flags.
 * Assumes the host holds cmd_valid for one cycle per command and that
 * bit-started commands arrive on their own ports in the same clock domain.
 */
`timescale 1ns/1ns
`include "hs_start_consts.svh"

// Function
// - Immediate path: upper byte 00 absolute, 01 relative; lower byte axis.
// - Unit-write path: upper byte 80 absolute, 81 relative; lower byte axis.
// - Axis byte 01 to 10 hex maps to axes 1 to 16.
// - Destination code 8000 to 800F must match own unit number.
// - Unit-write word count must be twelve.
// - Immediate start goes at once; unit-write waits for next control cycle.
// - Each command starts exactly one axis.
// - Only absolute or relative moves; no interrupt feeding via this path.
// - New start refused while previous is starting; host retries.
// - Acceptance result returned as condition flags with equality flag.
// - Command-bit starts are accepted in the same period concurrently.
// - High-speed start behaves like a bit start using the axis block.
// - Reversing multi-start stops by deceleration or immediately per parameter.
// - Acknowledged flag on at least one cycle from next refresh.
// - Multi-start during interrupt feeding rejected with multi-start error.
module hs_start_decoder (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rstn,
    // Host command
    input  wire logic                 cmd_valid,
    input  wire hs_start_pkg::cmd_s   cmd,
    output hs_start_pkg::flags_s      flags_r,
    output logic                      flags_vld_r,
    // Unit configuration and timing
    input  wire logic [3:0]           unit_no,
    input  wire logic [15:0]          base_addr,
    input  wire logic                 ctrl_tick,
    input  wire logic                 refresh_tick,
    input  wire logic                 rev_imm_stop,
    // Command-bit starts
    input  wire logic [15:0]          bit_abs,
    input  wire logic [15:0]          bit_rel,
    // Axis state
    input  wire logic [15:0]          axis_busy,
    input  wire logic [15:0]          axis_intfeed,
    input  wire logic [15:0]          axis_reverse,
    // Start outputs
    output logic [15:0]               start_abs_r,
    output logic [15:0]               start_rel_r,
    output logic [15:0]               stop_imm_r,
    output hs_start_pkg::start_s      start_r,
    output logic [15:0]               hs_ack_r,
    output logic [15:0]               mserr_r
);

    // =================================================================
    // Decode
    // =================================================================
    logic                 ok;
    hs_start_pkg::start_s dec;

    ctrl_decode u_dec (
        .cmd       (cmd),
        .unit_no   (unit_no),
        .base_addr (base_addr),
        .ok        (ok),
        .dec       (dec)
    );

    // =================================================================
    // Sequencer state
    // =================================================================
    hs_start_pkg::seq_e   st_r,   st_nxt;
    hs_start_pkg::start_s pend_r, pend_nxt;
    hs_start_pkg::start_s start_nxt;
    hs_start_pkg::flags_s flags_nxt;
    logic                 flags_vld_nxt;
    logic                 hs_go;
    logic                 ack_pend_r, ack_pend_nxt;
    logic [3:0]           ack_ax_r,   ack_ax_nxt;
    logic [1:0]           ack_cnt_r,  ack_cnt_nxt;
    logic [15:0]          hs_ack_nxt;
    logic                 rej_feed;
    logic                 take;
    logic                 feed_rej;

    // Accept, hold and launch one high-speed start at a time.
    always_comb begin
        st_nxt        = st_r;
        pend_nxt      = pend_r;
        flags_nxt     = flags_r;
        flags_vld_nxt = 1'b0;
        hs_go         = 1'b0;
        start_nxt     = start_r;
        rej_feed      = axis_intfeed[dec.axis];
        take          = 1'b0;
        feed_rej      = 1'b0;
        if (cmd_valid) begin
            flags_vld_nxt = 1'b1;
            if (st_r != hs_start_pkg::ST_IDLE) begin
                flags_nxt = '{eq: 1'b0, err: 1'b0};
            end else if (!ok) begin
                flags_nxt = '{eq: 1'b0, err: 1'b1};
            end else if (rej_feed && axis_busy[dec.axis]) begin
                flags_nxt = '{eq: 1'b0, err: 1'b1};
                feed_rej  = 1'b1;
            end else begin
                flags_nxt = '{eq: 1'b1, err: 1'b0};
                take      = 1'b1;
            end
        end
        case (st_r)
            hs_start_pkg::ST_IDLE: begin
                if (take && cmd.imm) begin
                    hs_go     = 1'b1;
                    start_nxt = dec;
                    st_nxt    = hs_start_pkg::ST_BUSY;
                end else if (take) begin
                    pend_nxt = dec;
                    st_nxt   = hs_start_pkg::ST_WAIT;
                end
            end
            hs_start_pkg::ST_WAIT: begin
                if (ctrl_tick) begin
                    hs_go     = 1'b1;
                    start_nxt = pend_r;
                    st_nxt    = hs_start_pkg::ST_BUSY;
                end
            end
            hs_start_pkg::ST_BUSY: begin
                if (!ack_pend_r && ack_cnt_r == 2'h0) begin
                    st_nxt = hs_start_pkg::ST_IDLE;
                end
            end
            default: st_nxt = hs_start_pkg::ST_IDLE;
        endcase
    end

    // Acknowledge flag: armed on launch, raised at next refresh, held.
    always_comb begin
        ack_pend_nxt = ack_pend_r;
        ack_ax_nxt   = ack_ax_r;
        ack_cnt_nxt  = ack_cnt_r;
        hs_ack_nxt   = hs_ack_r;
        if (ack_cnt_r != 2'h0) begin
            ack_cnt_nxt = ack_cnt_r - 2'h1;
        end else if (!ack_pend_r) begin
            hs_ack_nxt = '0;
        end
        if (ack_pend_r && refresh_tick) begin
            ack_pend_nxt         = 1'b0;
            hs_ack_nxt           = '0;
            hs_ack_nxt[ack_ax_r] = 1'b1;
            ack_cnt_nxt          = `ACK_HOLD;
        end
        if (hs_go) begin
            ack_pend_nxt = 1'b1;
            ack_ax_nxt   = start_nxt.axis;
        end
    end

    // =================================================================
    // Start merge with command bits, per axis
    // =================================================================
    logic [15:0] abs_nxt, rel_nxt, stop_nxt, err_nxt;

    generate
        for (genvar a = 0; a < `AXES; a++) begin : g_axis
            logic hs_here;
            logic hs_rej;
            logic want_abs, want_rel, any_req;
            always_comb begin
                hs_here  = hs_go && (start_nxt.axis == 4'(a));
                want_abs = bit_abs[a] || (hs_here && !start_nxt.rel);
                want_rel = bit_rel[a] || (hs_here && start_nxt.rel);
                any_req  = want_abs || want_rel;
                // A high-speed start refused for feeding raises the error too.
                hs_rej      = feed_rej && (dec.axis == 4'(a));
                err_nxt[a]  = (any_req && axis_busy[a] && axis_intfeed[a]) || hs_rej;
                abs_nxt[a]  = want_abs && !err_nxt[a];
                rel_nxt[a]  = want_rel && !err_nxt[a];
                stop_nxt[a] = any_req && !err_nxt[a] && axis_reverse[a] && rev_imm_stop;
            end
        end
    endgenerate

    // Registers of all state above.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_r        <= hs_start_pkg::ST_IDLE;
            pend_r      <= '0;
            start_r     <= '0;
            flags_r     <= '0;
            flags_vld_r <= 1'b0;
            ack_pend_r  <= 1'b0;
            ack_ax_r    <= '0;
            ack_cnt_r   <= '0;
            hs_ack_r    <= '0;
            start_abs_r <= '0;
            start_rel_r <= '0;
            stop_imm_r  <= '0;
            mserr_r     <= '0;
        end else begin
            st_r        <= st_nxt;
            pend_r      <= pend_nxt;
            start_r     <= start_nxt;
            flags_r     <= flags_nxt;
            flags_vld_r <= flags_vld_nxt;
            ack_pend_r  <= ack_pend_nxt;
            ack_ax_r    <= ack_ax_nxt;
            ack_cnt_r   <= ack_cnt_nxt;
            hs_ack_r    <= hs_ack_nxt;
            start_abs_r <= abs_nxt;
            start_rel_r <= rel_nxt;
            stop_imm_r  <= stop_nxt;
            mserr_r     <= err_nxt;
        end
    end

    // =================================================================
    // Checks
    // =================================================================
    busy_refuse_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd_valid && st_r != hs_start_pkg::ST_IDLE |=> !flags_r.eq && flags_vld_r)
        else $error("start taken while busy");
    imm_launch_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd_valid && cmd.imm && ok && st_r == hs_start_pkg::ST_IDLE && !(axis_busy[dec.axis]
        && axis_intfeed[dec.axis]) |=> $countones(start_abs_r | start_rel_r) >= 1)
        else $error("immediate start not launched");
    wr_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r == hs_start_pkg::ST_WAIT && !ctrl_tick |=> st_r == hs_start_pkg::ST_WAIT)
        else $error("unit-write start left before control cycle");
    bad_reject_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd_valid && !ok && st_r == hs_start_pkg::ST_IDLE |=> flags_r.err && !flags_r.eq)
        else $error("bad command not rejected");
    one_axis_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        bit_abs == '0 && bit_rel == '0 |=> $countones(start_abs_r | start_rel_r) <= 1)
        else $error("more than one axis started");
    feed_err_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (bit_abs[0] || bit_rel[0]) && axis_busy[0] && axis_intfeed[0] |=> mserr_r[0] && !start_abs_r[0])
        else $error("multi-start in feeding not rejected");
    ack_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(hs_ack_r != '0) |=> hs_ack_r != '0)
        else $error("acknowledge shorter than hold");
    bit_pass_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        bit_abs[1] && !(axis_busy[1] && axis_intfeed[1]) |=> start_abs_r[1])
        else $error("bit start lost");

endmodule // hs_start_decoder

//--- testbench/host_cpu.sv
/* Host controller model: issues one start command at a time and reads the result flags.
   Assumes the decoder answers on flags_vld_r one cycle after the command. */
`timescale 1ns/1ns
module host_cpu (
    // Clock
    input  wire logic                 clk_sys,
    // Answer from the decoder
    input  wire hs_start_pkg::flags_s flags_r,
    input  wire logic                 flags_vld_r,
    // Command to the decoder
    output logic                      cmd_valid,
    output hs_start_pkg::cmd_s        cmd
);
    // ==========================================
    // Command issue
    // Idle state of the command lines.
    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
    end

    // Sends one command; only one is in flight, and with retry it is resent every second cycle on a busy refusal.
    task automatic send(input hs_start_pkg::cmd_s c, input bit retry, output hs_start_pkg::flags_s f);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            cmd_valid <= 1'b1;
            cmd       <= c;
            @(posedge clk_sys);
            cmd_valid <= 1'b0;
            cmd       <= ~c; // Released lines show no stale command.
            #1;
            f = flags_vld_r === 1'b1 ? flags_r : 2'b11;
            n++;
        end while (retry && f === 2'b00 && n < 64);
    endtask
endmodule // host_cpu

//--- testbench/tb_top.sv
/* Testbench of the start decoder: table of commands, then busy, feeding and reset cases.
   Assumes the host model drives cmd and the bench drives the ticks and axis state. */
`timescale 1ns/1ns
module tb_top;
    // ==========================================
    // Signals
    localparam logic [15:0] BASE = 16'h0100;
    typedef struct { logic imm; logic [15:0] ctrl; logic [15:0] dest; logic [15:0] count; logic [1:0] fl; } row_s;
    logic                 clk_sys, rstn, cmd_valid, flags_vld_r, ctrl_tick, refresh_tick, rev_imm_stop;
    hs_start_pkg::cmd_s   cmd;
    hs_start_pkg::flags_s flags_r, f;
    hs_start_pkg::start_s start_r;
    logic [15:0]          bit_abs, bit_rel, axis_busy, axis_intfeed, axis_reverse;
    logic [3:0]           unit_no;
    logic [15:0]          start_abs_r, start_rel_r, stop_imm_r, hs_ack_r, mserr_r;
    int                   num_errors, check_count;
    row_s rows [11] = '{'{1, 16'h0001, 16'h8005, 16'h0000, 2'b10}, '{1, 16'h0110, 16'h8005, 16'h0000, 2'b10},
        '{0, 16'h8003, 16'h8005, 16'h000C, 2'b10}, '{0, 16'h8110, 16'h8005, 16'h000C, 2'b10},
        '{1, 16'h0203, 16'h8005, 16'h0000, 2'b01}, '{1, 16'h0100, 16'h8005, 16'h0000, 2'b01},
        '{1, 16'h0011, 16'h8005, 16'h0000, 2'b01}, '{1, 16'h0002, 16'h8004, 16'h0000, 2'b01},
        '{0, 16'h8002, 16'h8005, 16'h000B, 2'b01}, '{1, 16'h8002, 16'h8005, 16'h0000, 2'b01},
        '{0, 16'h0002, 16'h8005, 16'h000C, 2'b01}};

    host_cpu u_host_cpu (.clk_sys(clk_sys), .flags_r(flags_r), .flags_vld_r(flags_vld_r),
        .cmd_valid(cmd_valid), .cmd(cmd));
    hs_start_decoder u_hs_start_decoder (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
        .flags_r(flags_r), .flags_vld_r(flags_vld_r), .unit_no(unit_no), .base_addr(BASE), .ctrl_tick(ctrl_tick),
        .refresh_tick(refresh_tick), .rev_imm_stop(rev_imm_stop), .bit_abs(bit_abs), .bit_rel(bit_rel),
        .axis_busy(axis_busy), .axis_intfeed(axis_intfeed), .axis_reverse(axis_reverse),
        .start_abs_r(start_abs_r), .start_rel_r(start_rel_r), .stop_imm_r(stop_imm_r), .start_r(start_r),
        .hs_ack_r(hs_ack_r), .mserr_r(mserr_r));

    // ==========================================
    // Clock and watchdog
    // The 8 ns clock.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Cuts a hang short well beyond the expected run.
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        close_out();
    end

    // ==========================================
    // Tasks
    // Compares one value with its expectation.
    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Pulses the refresh tick and checks the two-cycle acknowledge.
    task automatic ack(input logic [15:0] m);
        @(posedge clk_sys);
        refresh_tick <= 1'b1;
        @(posedge clk_sys);
        refresh_tick <= 1'b0;
        #1 chk(hs_ack_r, m);
        @(posedge clk_sys);
        #1 chk(hs_ack_r, m);
        @(posedge clk_sys);
        #1 chk(hs_ack_r, 0);
    endtask
    // Runs one table row and checks flags, start pulses and the decoded block.
    task automatic go(input row_s r);
        logic [3:0]  a;
        logic [15:0] m;
        a = r.ctrl[3:0] - 4'h1;
        m = 16'h0001 << a;
        u_host_cpu.send('{r.imm, r.ctrl, r.dest, r.count, BASE + 16'd12 * a}, 1'b0, f);
        chk(f, r.fl);
        if (r.fl == 2'b10) begin
            if (!r.imm) begin
                chk(start_abs_r | start_rel_r, 0);
                @(posedge clk_sys);
                ctrl_tick <= 1'b1;
                @(posedge clk_sys);
                ctrl_tick <= 1'b0;
                #1;
            end
            chk({start_rel_r, start_abs_r}, r.ctrl[8] ? {m, 16'h0000} : {16'h0000, m});
            chk(start_r, {r.ctrl[8], a, BASE + 16'd12 * a});
            ack(m);
        end else begin
            chk(start_abs_r | start_rel_r, 0);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        {rstn, ctrl_tick, refresh_tick, rev_imm_stop} = 4'h0;
        {bit_abs, bit_rel, axis_busy, axis_intfeed, axis_reverse} = '0;
        unit_no = 4'h5;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        #1 chk({flags_vld_r, start_abs_r, start_rel_r, hs_ack_r, mserr_r}, 0);
        foreach (rows[i]) go(rows[i]);
        // Reversing start merged with a bit start, a busy refusal, then a retried start.
        axis_reverse <= 16'h000C;
        rev_imm_stop <= 1'b1;
        fork
            u_host_cpu.send('{1, 16'h0003, 16'h8005, 16'h0000, BASE + 16'd24}, 1'b0, f);
            begin
                @(posedge clk_sys);
                bit_rel <= 16'h0020;
                @(posedge clk_sys);
                bit_rel <= 16'h0000;
            end
        join
        chk({start_rel_r, start_abs_r, stop_imm_r}, {16'h0020, 16'h0004, 16'h0004});
        u_host_cpu.send('{1, 16'h0004, 16'h8005, 16'h0000, BASE + 16'd36}, 1'b0, f);
        chk(f, 2'b00);
        rev_imm_stop <= 1'b0;
        fork
            u_host_cpu.send('{1, 16'h0004, 16'h8005, 16'h0000, BASE + 16'd36}, 1'b1, f);
            ack(16'h0004);
        join
        chk({f, start_abs_r, stop_imm_r}, {2'b10, 16'h0008, 16'h0000});
        ack(16'h0008);
        // Start towards an axis in interrupt feeding.
        axis_busy <= 16'h0040;
        axis_intfeed <= 16'h0040;
        u_host_cpu.send('{1, 16'h0007, 16'h8005, 16'h0000, BASE + 16'd72}, 1'b0, f);
        chk({f, mserr_r, start_abs_r}, {2'b01, 16'h0040, 16'h0000});
        // Reset while a unit-write start waits for its control cycle.
        u_host_cpu.send('{0, 16'h8002, 16'h8005, 16'h000C, BASE + 16'd12}, 1'b0, f);
        chk(f, 2'b10);
        @(posedge clk_sys);
        rstn <= 1'b0;
        @(posedge clk_sys);
        rstn <= 1'b1;
        ctrl_tick <= 1'b1;
        #1 chk({flags_vld_r, start_abs_r, hs_ack_r}, 0);
        @(posedge clk_sys);
        ctrl_tick <= 1'b0;
        #1 chk(start_abs_r, 0);
        // The highest unit number is matched as well.
        unit_no <= 4'hF;
        go('{1, 16'h0002, 16'h800F, 16'h0000, 2'b10});
        close_out();
    end
endmodule // tb_top
